/* File: bench/ebrc_ext_model.sv */
// Behavioural model of the external access sequencer and bus pins.
`timescale 1ns/1ps
module ebrc_ext_model (
  input  wire logic            clk_in,
  output logic                 start_out,
  output logic                 end_out,
  output logic [2:0]           region_out,
  output logic                 write_out,
  output logic                 code_out,
  output ebrc_pkg::ebrc_timing_s timing_out,
  output logic                 side_out,
  output logic                 hold_pin_out,
  output logic                 cmd_pin_out
);
  // Idle state; both hold pins rest low between accesses.
  initial
  begin
    start_out = 1'b0;
    end_out = 1'b0;
    region_out = 3'h0;
    write_out = 1'b0;
    code_out = 1'b0;
    timing_out = '0;
    side_out = 1'b0;
    hold_pin_out = 1'b0;
    cmd_pin_out = 1'b0;
  end

  // Starts one access; both hold pins rise with it and side conditions follow s.
  task begin_acc(input logic [2:0] r, input logic w, input logic c,
                 input ebrc_pkg::ebrc_timing_s t, input logic s);
    start_out <= 1'b1;
    region_out <= r;
    write_out <= w;
    code_out <= c;
    timing_out <= t;
    side_out <= s;
    hold_pin_out <= 1'b1;
    cmd_pin_out <= 1'b1;
    @(posedge clk_in);
    start_out <= 1'b0;
  endtask

  // Ends the access and waits for the idle cycle before the next start.
  task end_acc;
    end_out <= 1'b1;
    @(posedge clk_in);
    end_out <= 1'b0;
    side_out <= 1'b0;
    hold_pin_out <= 1'b0;
    cmd_pin_out <= 1'b0;
    @(posedge clk_in);
  endtask
endmodule

/* File: bench/ebrc_region_cfg_asserts.sv */
// Port-level checks on the region configuration bank.
`timescale 1ns/1ps
`include "ebrc_consts.svh"
module ebrc_region_cfg_asserts (
  input wire logic                    SYS_CLK_IN,
  input wire logic                    SYS_RST_IN,
  input wire logic                    PWRITE_IN,
  input wire logic [`EBRC_ADDR_W-1:0] PADDR_IN,
  input wire logic [31:0]             PRDATA_OUT,
  input wire logic                    PREADY_OUT,
  input wire logic                    ACC_START_IN,
  input wire logic [2:0]              ACC_REGION_IN,
  input wire ebrc_pkg::ebrc_timing_s  ACC_TIMING_IN,
  input wire ebrc_pkg::ebrc_cfg_s     ACC_CFG_OUT,
  input wire ebrc_pkg::ebrc_eff_t     ACC_CYCLES_OUT,
  input wire logic                    ACC_BUSY_OUT,
  input wire logic                    ACC_WR_BLOCKED_OUT,
  input wire logic                    USE_PREFETCH_OUT
);
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (SYS_RST_IN);

  // Local scaling model, kept apart from the design's own decode.
  function automatic logic [8:0] scaled(input logic [3:0] n, input logic [2:0] c, input logic u);
    logic [8:0] m;
    case (c)
      3'h1: m = 9'h004;
      3'h2: m = 9'h008;
      3'h3: m = 9'h010;
      3'h4: m = 9'h020;
      default: m = 9'h001;
    endcase
    if (!u)
      m = 9'h001;
    return {5'h00, n} * m;
  endfunction

  // An accepted start on a mapped region.
  sequence s_start;
    !ACC_BUSY_OUT && ACC_START_IN && ACC_REGION_IN != 3'h7;
  endsequence

  a_rsvd_read_zero: assert property (PREADY_OUT && !PWRITE_IN && PADDR_IN < 12'h01c
    |-> (PRDATA_OUT & 32'h0000_1e80) == 32'h0) else $error("reserved bits read nonzero");
  a_cfg_rsvd_zero: assert property (ACC_BUSY_OUT
    |-> ACC_CFG_OUT.rsvd_hi == 4'h0 && !ACC_CFG_OUT.rsvd_lo) else $error("snapshot rsvd set");
  a_region_bound: assert property (!ACC_BUSY_OUT && ACC_START_IN && ACC_REGION_IN == 3'h7
    |=> !ACC_BUSY_OUT) else $error("region 7 started an access");
  a_busy_follows: assert property (s_start |=> ACC_BUSY_OUT) else $error("start not taken");
  a_cfg_frozen: assert property (ACC_BUSY_OUT && $past(ACC_BUSY_OUT)
    |-> $stable(ACC_CFG_OUT)) else $error("config changed mid access");
  a_wr_blocked: assert property (ACC_WR_BLOCKED_OUT
    |-> ACC_BUSY_OUT && ACC_CFG_OUT.wr_protect) else $error("block without protection");
  a_idle_scaled: assert property (s_start |=> ACC_CYCLES_OUT[10] ==
    scaled($past(ACC_TIMING_IN.region_idle), ACC_CFG_OUT.cycle_mult, 1'b1))
    else $error("region idle count not scaled");
  a_masked_scale: assert property (s_start |=> ACC_CYCLES_OUT[0] ==
    scaled({2'h0, $past(ACC_TIMING_IN.addr_cyc)}, ACC_CFG_OUT.cycle_mult, ACC_CFG_OUT.mult_mask[0]))
    else $error("address count scaling wrong");
  a_policy_idle: assert property (!ACC_BUSY_OUT ##1 !ACC_BUSY_OUT
    |-> !USE_PREFETCH_OUT) else $error("prefetch policy while idle");
endmodule

bind ebrc_region_cfg ebrc_region_cfg_asserts i_chk (
  .SYS_CLK_IN(SYS_CLK_IN), .SYS_RST_IN(SYS_RST_IN), .PWRITE_IN(PWRITE_IN),
  .PADDR_IN(PADDR_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
  .ACC_START_IN(ACC_START_IN), .ACC_REGION_IN(ACC_REGION_IN), .ACC_TIMING_IN(ACC_TIMING_IN),
  .ACC_CFG_OUT(ACC_CFG_OUT), .ACC_CYCLES_OUT(ACC_CYCLES_OUT), .ACC_BUSY_OUT(ACC_BUSY_OUT),
  .ACC_WR_BLOCKED_OUT(ACC_WR_BLOCKED_OUT), .USE_PREFETCH_OUT(USE_PREFETCH_OUT)
);

/* File: bench/ebrc_region_cfg_test.sv */
// Self-checking testbench for the region configuration bank.
`timescale 1ns/1ps
module ebrc_region_cfg_test;
  logic clk, rst, boot, psel, pen, pwr, rdy, err, slv, st, en, wr, cd, sd, hp, cp;
  logic [11:0] paddr;
  logic [31:0] pwd, prd, rdata;
  logic [2:0] rg;
  ebrc_pkg::ebrc_timing_s tm;
  ebrc_pkg::ebrc_cfg_s cfg;
  ebrc_pkg::ebrc_eff_t cyc;
  logic busy, blk, rwb, upf, abt, wact, cact;
  int bad_count, n_checks;
  int cnts[11] = '{3, 2, 5, 4, 1, 3, 7, 7, 6, 9, 15};
  int mt[5] = '{1, 4, 8, 16, 32};
  // Raw counts; index order of cnts follows the effective count vector.
  localparam ebrc_pkg::ebrc_timing_s TMG =
    {2'h3, 2'h2, 3'h5, 3'h7, 3'h6, 3'h4, 2'h1, 3'h3, 3'h7, 4'h9, 4'hf};

  ebrc_region_cfg i_dut (
    .SYS_CLK_IN(clk), .SYS_RST_IN(rst), .EXT_BOOT_IN(boot), .PSEL_IN(psel),
    .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwd),
    .PSTRB_IN(4'hf), .PRDATA_OUT(prd), .PREADY_OUT(rdy), .PSLVERR_OUT(slv),
    .ACC_START_IN(st), .ACC_END_IN(en), .ACC_REGION_IN(rg), .ACC_WRITE_IN(wr),
    .ACC_CODE_IN(cd), .ACC_TIMING_IN(tm), .WBUF_HIT_IN(sd), .PREFETCH_BUSY_IN(sd),
    .DATA_REQ_IN(sd), .HOLD_PIN_IN(hp), .COMMAND_HOLD_PIN_IN(cp), .ACC_CFG_OUT(cfg),
    .ACC_CYCLES_OUT(cyc), .ACC_BUSY_OUT(busy), .ACC_WR_BLOCKED_OUT(blk),
    .READ_FROM_WBUF_OUT(rwb), .USE_PREFETCH_OUT(upf), .PREFETCH_ABORT_OUT(abt),
    .WAIT_ACTIVE_OUT(wact), .CMD_HOLD_ACTIVE_OUT(cact)
  );

  ebrc_ext_model i_ext (
    .clk_in(clk), .start_out(st), .end_out(en), .region_out(rg), .write_out(wr),
    .code_out(cd), .timing_out(tm), .side_out(sd), .hold_pin_out(hp), .cmd_pin_out(cp)
  );

  // Free-running 50 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task conclude;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One APB transfer; request held until ready is sampled high.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (rdy !== 1'b1 && n < 16);
    rdata = prd;
    err = slv;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk); // Idle edge, so a following call never reassigns psel in this step.
    if (n >= 16)
    begin
      bad_count++;
      conclude();
    end
  endtask

  task reset_dut(input logic b);
    rst <= 1'b1;
    boot <= b;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
  endtask

  // Compares all eleven effective counts; fixed waits are always scaled.
  task chk_cyc(input int m, input logic [7:0] mask);
    for (int i = 0; i < 11; i++)
      chk("cycles", 32'(cnts[i] * ((i > 6 || mask[i]) ? m : 1)), 32'(cyc[i]));
  endtask

  // Distinct pattern per region, with reserved bits deliberately set.
  function automatic logic [31:0] pat(input int r);
    return (32'(r % 5) << 28) | (32'(r % 5) << 13) | 32'h0959_1f80 | (32'h1 << r);
  endfunction

  // Main sequence.
  initial
  begin
    rst = 1'b1;
    boot = 1'b0;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 12'h000;
    pwd = 32'h0;
    reset_dut(1'b0);
    for (int r = 0; r < 7; r++)
    begin
      apb(1'b0, 12'(4 * r), 32'h0);
      chk("reset cfg", 32'h8092_8000, rdata);
      apb(1'b1, 12'(4 * r), pat(r));
    end
    apb(1'b0, 12'h01c, 32'h0);
    chk("unmapped err", 32'h1, 32'(err));
    for (int r = 0; r < 7; r++)
    begin
      apb(1'b0, 12'(4 * r), 32'h0);
      chk("readback", pat(r) & ~32'h0000_1e80, rdata);
      i_ext.begin_acc(3'(r), 1'b1, 1'b0, TMG, 1'b0);
      @(posedge clk);
      chk("acc cfg", pat(r) & ~32'h0000_1e80, cfg);
      chk("blocked", 32'h0, 32'(blk));
      chk_cyc(mt[r % 5], 8'(1 << r));
      repeat (3) @(posedge clk);
      chk("wait act", 32'h1, 32'(wact));
      chk("cmd act", 32'h1, 32'(cact));
      i_ext.end_acc();
    end
    i_ext.begin_acc(3'h7, 1'b0, 1'b0, TMG, 1'b0);
    @(posedge clk);
    chk("r7 busy", 32'h0, 32'(busy));
    i_ext.end_acc();
    reset_dut(1'b1);
    apb(1'b0, 12'h008, 32'h0);
    chk("ext cfg", 32'h8092_807f, rdata);
    apb(1'b0, 12'h020, 32'h0);
    chk("status", 32'h0000_0040, rdata);
    i_ext.begin_acc(3'h2, 1'b1, 1'b0, TMG, 1'b1);
    @(posedge clk);
    chk("blocked", 32'h1, 32'(blk));
    chk_cyc(32, 8'h7f);
    apb(1'b1, 12'h008, 32'h0004_0100);
    @(posedge clk);
    chk("cfg held", 32'h8092_807f, cfg);
    chk("wait off", 32'h0, 32'(wact));
    chk("cmd off", 32'h0, 32'(cact));
    chk("no abort", 32'h0, 32'(abt));
    i_ext.end_acc();
    i_ext.begin_acc(3'h2, 1'b0, 1'b1, TMG, 1'b1);
    repeat (2) @(posedge clk);
    chk("prefetch", 32'h1, 32'(upf));
    chk("abort", 32'h1, 32'(abt));
    i_ext.end_acc();
    i_ext.begin_acc(3'h2, 1'b0, 1'b0, TMG, 1'b1);
    repeat (2) @(posedge clk);
    chk("wbuf read", 32'h1, 32'(rwb));
    chk_cyc(1, 8'h00);
    i_ext.end_acc();
    conclude();
  end

  // Cuts a hang short.
  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    conclude();
  end
endmodule

/* File: design/ebrc_consts.svh */
// Constants for the per-region external bus configuration register bank.
// Summary of operation
// - Seven independent configuration copies, one for each external memory region.
// - Reset loads 0x80928000, or 0x8092807F after external boot.
// - Bits 15:13 pick multiplier 1, 4, 8, 16 or 32; 32 at reset.
// - Wait, turnaround and cross-region idle counts are always scaled.
// - Mask bits 6:0 choose which seven programmable counts get scaled.
// - Bit 8 set lets a data access abort a running prefetch.
// - Bit 16 picks byte order: 0 little endian, 1 big endian.
// - Bit 17 decides if reads may be served from the write buffer.
// - Bit 18 sends every code fetch through the prefetch buffer, or none.
// - Bit 19 sets wait input polarity: 0 active low, 1 active high.
// - Bits 21:20 pick byte strobe timing; follow read control at reset.
// - Bits 23:22 pick port width: 01 is 16 bits, 10 is 32.
// - Bits 25:24 ignore, asynchronously or synchronously sample the wait input.
// - Bits 27:26 ignore, asynchronously or synchronously use the command delay input.
// - Bits 30:28 pick demux, mux, burst flash, SDRAM type 0 or 1.
// - Bit 31 set blocks writes to the region; set at reset.
// - Bits 7 and 12:9 read zero; software writes zero.
// - An access uses the copy of the region whose address match hit.
// - A masked count becomes programmed count times multiplier, else unscaled.
`ifndef EBRC_CONSTS_SVH
`define EBRC_CONSTS_SVH

`define EBRC_NUM_REGIONS   7
`define EBRC_ADDR_W        12
`define EBRC_CFG_LAST_IDX  10'd6
`define EBRC_STAT_IDX      10'd8
`define EBRC_RST_INT_BOOT  32'h8092_8000
`define EBRC_RST_EXT_BOOT  32'h8092_807f
`define EBRC_RSVD_MASK     32'h0000_1e80
`define EBRC_SHIFT_X1      3'h0
`define EBRC_SHIFT_X4      3'h2
`define EBRC_SHIFT_X8      3'h3
`define EBRC_SHIFT_X16     3'h4
`define EBRC_SHIFT_X32     3'h5
`define EBRC_NUM_COUNTS    11
`define EBRC_NUM_MASKED    7
`define EBRC_CNT_W         4
`define EBRC_EFF_W         9
`define EBRC_MODE_OFF      2'h0
`define EBRC_MODE_ASYNC    2'h1
`define EBRC_MODE_SYNC     2'h2
`define EBRC_WIDTH_16      2'h1
`define EBRC_WIDTH_32      2'h2
`define EBRC_STYLE_LAST    3'h4

`endif

/* File: design/ebrc_pkg.sv */
// Types and shared decode functions for the region configuration bank.
`include "ebrc_consts.svh"
package ebrc_pkg;

  // Field layout of one configuration copy, most significant bit first.
  typedef struct packed {
    logic       wr_protect;
    logic [2:0] addressing_style;
    logic [1:0] ext_command_hold_input_mode;
    logic [1:0] wait_mode;
    logic [1:0] bus_width_select;
    logic [1:0] byte_lane_strobe_timing;
    logic       hold_pin_polarity_flip;
    logic       prefetch_all_code;
    logic       force_external_fetch;
    logic       big_endian;
    logic [2:0] cycle_mult;
    logic [3:0] rsvd_hi;
    logic       abortable_lookahead;
    logic       rsvd_lo;
    logic [6:0] mult_mask;
  } ebrc_cfg_s;

  // Raw access timing counts as held by the neighbouring parameter register.
  typedef struct packed {
    logic [1:0] addr_cyc;
    logic [1:0] addr_hold;
    logic [2:0] cmd_delay;
    logic [2:0] wait_rd;
    logic [2:0] wait_wr;
    logic [2:0] burst_cyc;
    logic [1:0] data_hold;
    logic [2:0] rd_recov;
    logic [2:0] wr_recov;
    logic [3:0] rdwr_idle;
    logic [3:0] region_idle;
  } ebrc_timing_s;

  // Effective cycle counts; index 0..6 follow the mask bits, 7..10 always scale.
  typedef logic [`EBRC_NUM_COUNTS-1:0][`EBRC_EFF_W-1:0] ebrc_eff_t;

  // Multiplier code to shift distance; reserved codes fall back to times one.
  function automatic logic [2:0] mult_shift(input logic [2:0] code);
    logic [2:0] sh;
    sh = `EBRC_SHIFT_X1;
    unique case (code)
      3'h1:    sh = `EBRC_SHIFT_X4;
      3'h2:    sh = `EBRC_SHIFT_X8;
      3'h3:    sh = `EBRC_SHIFT_X16;
      3'h4:    sh = `EBRC_SHIFT_X32;
      default: sh = `EBRC_SHIFT_X1;
    endcase
    return sh;
  endfunction

  // True when any multi-bit field holds a reserved code.
  function automatic logic cfg_reserved(input ebrc_cfg_s c);
    return (c.cycle_mult > `EBRC_SHIFT_X8 + 3'h1) ||
           (c.bus_width_select != `EBRC_WIDTH_16 && c.bus_width_select != `EBRC_WIDTH_32) ||
           (c.wait_mode == 2'h3) || (c.ext_command_hold_input_mode == 2'h3) ||
           (c.addressing_style > `EBRC_STYLE_LAST);
  endfunction

endpackage

/* File: design/ebrc_region_cfg.sv */
// APB register bank of seven region configuration copies with access-time decode.
//
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "ebrc_consts.svh"
module ebrc_region_cfg (
  input  wire logic                      SYS_CLK_IN,
  input  wire logic                      SYS_RST_IN,
  input  wire logic                      EXT_BOOT_IN,
  input  wire logic                      PSEL_IN,
  input  wire logic                      PENABLE_IN,
  input  wire logic                      PWRITE_IN,
  input  wire logic [`EBRC_ADDR_W-1:0]   PADDR_IN,
  input  wire logic [31:0]               PWDATA_IN,
  input  wire logic [3:0]                PSTRB_IN,
  output logic      [31:0]               PRDATA_OUT,
  output logic                           PREADY_OUT,
  output logic                           PSLVERR_OUT,
  input  wire logic                      ACC_START_IN,
  input  wire logic                      ACC_END_IN,
  input  wire logic [2:0]                ACC_REGION_IN,
  input  wire logic                      ACC_WRITE_IN,
  input  wire logic                      ACC_CODE_IN,
  input  wire ebrc_pkg::ebrc_timing_s    ACC_TIMING_IN,
  input  wire logic                      WBUF_HIT_IN,
  input  wire logic                      PREFETCH_BUSY_IN,
  input  wire logic                      DATA_REQ_IN,
  input  wire logic                      HOLD_PIN_IN,
  input  wire logic                      COMMAND_HOLD_PIN_IN,
  output ebrc_pkg::ebrc_cfg_s            ACC_CFG_OUT,
  output ebrc_pkg::ebrc_eff_t            ACC_CYCLES_OUT,
  output logic                           ACC_BUSY_OUT,
  output logic                           ACC_WR_BLOCKED_OUT,
  output logic                           READ_FROM_WBUF_OUT,
  output logic                           USE_PREFETCH_OUT,
  output logic                           PREFETCH_ABORT_OUT,
  output logic                           WAIT_ACTIVE_OUT,
  output logic                           CMD_HOLD_ACTIVE_OUT
);

  // Access tracking state.
  typedef enum logic [1:0] {
    EBRC_IDLE   = 2'b01,
    EBRC_ACTIVE = 2'b10
  } ebrc_acc_e;

  localparam int NR = `EBRC_NUM_REGIONS;

  logic [NR-1:0][31:0]  cfg_q;
  logic [NR-1:0][31:0]  cfg_d;
  logic [31:0]          rst_val;
  ebrc_acc_e            state_q;
  ebrc_acc_e            state_d;
  ebrc_pkg::ebrc_cfg_s  act_q;
  ebrc_pkg::ebrc_cfg_s  act_d;
  ebrc_pkg::ebrc_cfg_s  sel_cfg;
  ebrc_pkg::ebrc_eff_t  eff;
  ebrc_pkg::ebrc_eff_t  cyc_q;
  ebrc_pkg::ebrc_eff_t  cyc_d;
  logic [2:0]           region_q;
  logic [2:0]           region_d;
  logic                 wr_q;
  logic                 wr_d;
  logic                 code_q;
  logic                 code_d;
  logic                 blk_q;
  logic                 blk_d;
  logic                 boot_q;
  logic                 rsvd_seen_q;
  logic                 rsvd_seen_d;
  logic                 start_ok;
  logic [9:0]           widx;
  logic                 wr_strobe;
  logic                 rd_strobe;
  logic                 mapped;
  logic [31:0]          prdata_q;
  logic [31:0]          prdata_d;
  logic                 pready_q;
  logic                 pready_d;
  logic                 pslverr_q;
  logic                 pslverr_d;
  logic [3:0]           cnt_raw [`EBRC_NUM_COUNTS];
  logic [1:0]           pin_raw;
  logic [1:0]           pin_mode;
  logic [1:0]           pin_s1_q;
  logic [1:0]           pin_s2_q;
  logic [1:0]           pin_r_q;
  logic [1:0]           pin_act_q;
  logic [1:0]           pin_act_d;
  logic                 rb_q;
  logic                 rb_d;
  logic                 up_q;
  logic                 up_d;
  logic                 ab_q;
  logic                 ab_d;

  // Reset image is chosen by the boot strap seen while reset is held.
  assign rst_val = EXT_BOOT_IN ? `EBRC_RST_EXT_BOOT : `EBRC_RST_INT_BOOT;

  // APB decode: the slave answers in the first access cycle, no extra wait.
  assign widx      = PADDR_IN[`EBRC_ADDR_W-1:2];
  assign mapped    = (widx <= `EBRC_CFG_LAST_IDX) || (widx == `EBRC_STAT_IDX);
  assign wr_strobe = PSEL_IN && PENABLE_IN && pready_q && PWRITE_IN;
  assign rd_strobe = PSEL_IN && !PENABLE_IN && !PWRITE_IN;

  // Register file next values with byte strobes; reserved bits never store a one.
  always_comb
  begin
    cfg_d = cfg_q;
    for (int r = 0; r < NR; r++)
    begin
      if (wr_strobe && widx == 10'(r))
      begin
        for (int b = 0; b < 4; b++)
        begin
          if (PSTRB_IN[b])
          begin
            cfg_d[r][8*b +: 8] = PWDATA_IN[8*b +: 8];
          end
        end
        cfg_d[r] = cfg_d[r] & ~`EBRC_RSVD_MASK;
      end
    end
  end

  // Read data and handshake are staged in the setup cycle so they come from flops.
  always_comb
  begin
    prdata_d  = 32'h0;
    pready_d  = PSEL_IN && !PENABLE_IN;
    pslverr_d = PSEL_IN && !PENABLE_IN && !mapped;
    if (rd_strobe && widx <= `EBRC_CFG_LAST_IDX)
    begin
      prdata_d = cfg_q[widx[2:0]] & ~`EBRC_RSVD_MASK;
    end
    else if (rd_strobe && widx == `EBRC_STAT_IDX)
    begin
      prdata_d = {25'h0, boot_q, rsvd_seen_q, state_q == EBRC_ACTIVE, 1'b0, region_q};
    end
  end

  // Register bank and bus answer registers.
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      for (int r = 0; r < NR; r++)
      begin
        cfg_q[r] <= rst_val;
      end
      boot_q    <= EXT_BOOT_IN;
      prdata_q  <= 32'h0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      cfg_q     <= cfg_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // Region choice comes from the address match of the access being started.
  assign sel_cfg  = ebrc_pkg::ebrc_cfg_s'(cfg_q[ACC_REGION_IN]);
  assign start_ok = ACC_START_IN && state_q == EBRC_IDLE && ACC_REGION_IN < 3'(NR);

  // Unpack the raw counts; order of the first seven matches the mask bits.
  always_comb
  begin
    cnt_raw[0]  = {2'h0, ACC_TIMING_IN.addr_cyc};
    cnt_raw[1]  = {2'h0, ACC_TIMING_IN.addr_hold};
    cnt_raw[2]  = {1'h0, ACC_TIMING_IN.cmd_delay};
    cnt_raw[3]  = {1'h0, ACC_TIMING_IN.burst_cyc};
    cnt_raw[4]  = {2'h0, ACC_TIMING_IN.data_hold};
    cnt_raw[5]  = {1'h0, ACC_TIMING_IN.rd_recov};
    cnt_raw[6]  = {1'h0, ACC_TIMING_IN.wr_recov};
    cnt_raw[7]  = {1'h0, ACC_TIMING_IN.wait_rd};
    cnt_raw[8]  = {1'h0, ACC_TIMING_IN.wait_wr};
    cnt_raw[9]  = ACC_TIMING_IN.rdwr_idle;
    cnt_raw[10] = ACC_TIMING_IN.region_idle;
  end

  // One scaler per count; the last four ignore the mask and always scale.
  for (genvar g = 0; g < `EBRC_NUM_COUNTS; g++)
  begin : g_scale
    ebrc_scale #(
      .CW (`EBRC_CNT_W),
      .OW (`EBRC_EFF_W)
    ) u_scale (
      .count_in     (cnt_raw[g]),
      .mult_code_in (sel_cfg.cycle_mult),
      .use_mult_in  ((g >= `EBRC_NUM_MASKED) || sel_cfg.mult_mask[g % `EBRC_NUM_MASKED]),
      .cycles_out   (eff[g])
    );
  end

  // Snapshot at access start so later writes do not disturb the running access.
  always_comb
  begin
    state_d     = state_q;
    act_d       = act_q;
    cyc_d       = cyc_q;
    region_d    = region_q;
    wr_d        = wr_q;
    code_d      = code_q;
    blk_d       = blk_q;
    rsvd_seen_d = rsvd_seen_q;
    unique case (state_q)
      EBRC_IDLE:
      begin
        if (start_ok)
        begin
          state_d     = EBRC_ACTIVE;
          act_d       = sel_cfg;
          cyc_d       = eff;
          region_d    = ACC_REGION_IN;
          wr_d        = ACC_WRITE_IN;
          code_d      = ACC_CODE_IN;
          blk_d       = ACC_WRITE_IN && sel_cfg.wr_protect;
          rsvd_seen_d = rsvd_seen_q || ebrc_pkg::cfg_reserved(sel_cfg);
        end
      end
      EBRC_ACTIVE:
      begin
        if (ACC_END_IN)
        begin
          state_d = EBRC_IDLE;
          blk_d   = 1'b0;
        end
      end
      default:
      begin
        state_d = EBRC_IDLE;
      end
    endcase
  end

  // Access state registers.
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      state_q     <= EBRC_IDLE;
      act_q       <= ebrc_pkg::ebrc_cfg_s'(`EBRC_RST_INT_BOOT);
      cyc_q       <= '0;
      region_q    <= 3'h0;
      wr_q        <= 1'b0;
      code_q      <= 1'b0;
      blk_q       <= 1'b0;
      rsvd_seen_q <= 1'b0;
    end
    else
    begin
      state_q     <= state_d;
      act_q       <= act_d;
      cyc_q       <= cyc_d;
      region_q    <= region_d;
      wr_q        <= wr_d;
      code_q      <= code_d;
      blk_q       <= blk_d;
      rsvd_seen_q <= rsvd_seen_d;
    end
  end

  // Wait and command delay pins share one conditioning path each.
  assign pin_raw  = {COMMAND_HOLD_PIN_IN, HOLD_PIN_IN};
  assign pin_mode = {act_q.ext_command_hold_input_mode[1] | act_q.ext_command_hold_input_mode[0],
                     act_q.wait_mode[1] | act_q.wait_mode[0]};

  // Asynchronous mode goes through two flops; synchronous mode costs one.
  always_comb
  begin
    for (int p = 0; p < 2; p++)
    begin
      pin_act_d[p] = 1'b0;
    end
    if (state_q == EBRC_ACTIVE)
    begin
      unique case (act_q.wait_mode)
        `EBRC_MODE_ASYNC: pin_act_d[0] = pin_s2_q[0] ^ ~act_q.hold_pin_polarity_flip;
        `EBRC_MODE_SYNC:  pin_act_d[0] = pin_r_q[0] ^ ~act_q.hold_pin_polarity_flip;
        default:          pin_act_d[0] = 1'b0;
      endcase
      unique case (act_q.ext_command_hold_input_mode)
        `EBRC_MODE_ASYNC: pin_act_d[1] = pin_s2_q[1];
        `EBRC_MODE_SYNC:  pin_act_d[1] = pin_r_q[1];
        default:          pin_act_d[1] = 1'b0;
      endcase
      pin_act_d = pin_act_d & pin_mode;
    end
  end

  // Pin conditioning registers.
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      pin_s1_q  <= 2'h0;
      pin_s2_q  <= 2'h0;
      pin_r_q   <= 2'h0;
      pin_act_q <= 2'h0;
    end
    else
    begin
      pin_s1_q  <= pin_raw;
      pin_s2_q  <= pin_s1_q;
      pin_r_q   <= pin_raw;
      pin_act_q <= pin_act_d;
    end
  end

  // Buffer policy decisions for the running access.
  always_comb
  begin
    rb_d = state_q == EBRC_ACTIVE && !wr_q && !code_q && WBUF_HIT_IN &&
           !act_q.force_external_fetch;
    up_d = state_q == EBRC_ACTIVE && code_q && act_q.prefetch_all_code;
    ab_d = state_q == EBRC_ACTIVE && PREFETCH_BUSY_IN && DATA_REQ_IN &&
           act_q.abortable_lookahead;
  end

  // Policy output registers.
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      rb_q <= 1'b0;
      up_q <= 1'b0;
      ab_q <= 1'b0;
    end
    else
    begin
      rb_q <= rb_d;
      up_q <= up_d;
      ab_q <= ab_d;
    end
  end

  // Byte order, strobe timing, width and style reach the bus engine as fields.
  assign ACC_CFG_OUT         = act_q;
  assign ACC_CYCLES_OUT      = cyc_q;
  assign ACC_BUSY_OUT        = state_q == EBRC_ACTIVE;
  assign ACC_WR_BLOCKED_OUT  = blk_q;
  assign READ_FROM_WBUF_OUT  = rb_q;
  assign USE_PREFETCH_OUT    = up_q;
  assign PREFETCH_ABORT_OUT  = ab_q;
  assign WAIT_ACTIVE_OUT     = pin_act_q[0];
  assign CMD_HOLD_ACTIVE_OUT = pin_act_q[1];
  assign PRDATA_OUT          = prdata_q;
  assign PREADY_OUT          = pready_q;
  assign PSLVERR_OUT         = pslverr_q;

endmodule

/* File: design/ebrc_scale.sv */
// Scales one programmed timing count by the region's cycle multiplier.
`timescale 1ns/1ps
`include "ebrc_consts.svh"
module ebrc_scale #(
  parameter int CW = `EBRC_CNT_W,
  parameter int OW = `EBRC_EFF_W
) (
  input  wire logic [CW-1:0] count_in,
  input  wire logic [2:0]    mult_code_in,
  input  wire logic          use_mult_in,
  output logic      [OW-1:0] cycles_out
);

  logic [OW-1:0] wide;

  // Shifting is exact because every multiplier is a power of two.
  always_comb
  begin
    wide = {{(OW-CW){1'b0}}, count_in};
    if (use_mult_in)
    begin
      cycles_out = wide << ebrc_pkg::mult_shift(mult_code_in);
    end
    else
    begin
      cycles_out = wide;
    end
  end

endmodule
